// [hw/sapc_pkg.sv]
// shared constants and state types of the service attribute pdu codec
package sapc_pkg;
    // data element header fields
    localparam logic [4:0] DE_TYPE_UINT = 5'h01;
    localparam logic [4:0] DE_TYPE_UUID = 5'h03;
    localparam logic [4:0] DE_TYPE_SEQ = 5'h06;
    localparam logic [2:0] DE_IDX_2B = 3'h1;
    localparam logic [2:0] DE_IDX_4B = 3'h2;
    localparam logic [2:0] DE_IDX_16B = 3'h4;
    localparam logic [2:0] DE_IDX_LEN8 = 3'h5;
    localparam logic [2:0] DE_IDX_LEN16 = 3'h6;
    localparam logic [7:0] ID_ELEM_HDR = 8'h09;
    localparam logic [7:0] SEQ16_HDR = 8'h36;
    localparam logic [4:0] LEN_2B = 5'h02;
    localparam logic [4:0] LEN_4B = 5'h04;
    localparam logic [4:0] LEN_16B = 5'h10;
    // field sizes and limits
    localparam logic [15:0] SEQ_HDR_LEN = 16'h0003;
    localparam logic [15:0] ID_ELEM_LEN = 16'h0003;
    localparam logic [15:0] LIMIT_MIN = 16'h0009;
    localparam logic [3:0] UUID_MAX = 4'hc;
    localparam logic [7:0] CONT_MAX = 8'h10;
    localparam logic [7:0] TOKEN_LEN = 8'h02;
    localparam int RANGE_MAX = 8;
    localparam logic [3:0] RANGE_MAX_CNT = 4'h8;
    localparam logic [15:0] ID_FIRST = 16'h0000;
    localparam logic [15:0] ID_LAST = 16'hffff;
    // output buffer shape
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [2:0] {
        P_SEQ_HDR, P_SEQ_LEN, P_EL_HDR, P_EL_BODY, P_LIMIT, P_CONT_CNT, P_CONT_BYTE, P_END
    } sapc_pst_t;
    typedef enum logic [2:0] {
        E_IDLE, E_SIZE, E_HDR, E_ATTR, E_ID, E_VAL, E_CONT
    } sapc_est_t;
endpackage

// [hw/sapc_fifo.sv]
// byte fifo with valid and ready on both sides
module sapc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock, reset and enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    assign push = ce_i && in_valid_i && in_ready_o;
    assign pop = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// [hw/sapc_codec.sv]
// request checker and attribute response framer
// Operation
// - list bytes (sequence header included) never exceed limit; truncate ourselves
// - range element: upper half first, lower last
// - range 0x0000-0xffff selects every attribute
// - reply alternates identifier then value elements
// - only requested, non-null attributes returned
// - pairs go out by ascending identifier
// - complete reply ends with zero count byte
// - record handle returned like any attribute
// - two-byte list length precedes the list
module sapc_codec
    import sapc_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // request parameter bytes
    input wire logic req_valid_i,
    input wire logic [7:0] req_data_i,
    input wire logic req_last_i,
    output logic req_ready_o,
    // request status
    output logic req_done_o,
    output logic req_bad_o,
    output logic [15:0] reply_byte_limit_o,
    output logic select_all_o,
    // record attribute descriptors and value bytes
    input wire logic rec_attr_valid_i,
    input wire logic [15:0] rec_id_i,
    input wire logic rec_null_i,
    input wire logic [7:0] rec_vlen_i,
    input wire logic rec_attr_last_i,
    output logic rec_attr_ready_o,
    output logic rec_pass_o,
    input wire logic rec_byte_valid_i,
    input wire logic [7:0] rec_byte_i,
    output logic rec_byte_ready_o,
    // response bytes and busy flag
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic resp_last_o,
    input wire logic resp_ready_i,
    output logic busy_o
);
    sapc_pst_t pst;
    sapc_pst_t next_pst;
    sapc_est_t est;
    logic phase;
    logic [15:0] seq_rem;
    logic [4:0] el_rem;
    logic el32;
    logic lcnt;
    logic [23:0] shreg;
    logic [3:0] uuid_cnt;
    logic [3:0] nids;
    logic [15:0] rng_lo [RANGE_MAX];
    logic [15:0] rng_hi [RANGE_MAX];
    logic [7:0] tok_len;
    logic [15:0] tok;
    logic err_now;
    logic [4:0] el_len;
    logic [15:0] new_len;
    logic [31:0] ival;
    logic [15:0] v_start;
    logic [15:0] v_end;
    logic req_fire;
    logic after_seq_go;

    assign req_fire = ce_i && req_valid_i && req_ready_o;
    assign new_len = {seq_rem[7:0], req_data_i};
    assign ival = {shreg, req_data_i};
    assign v_start = el32 ? ival[31:16] : ival[15:0];
    assign v_end = ival[15:0];

    always_comb
    begin
        next_pst = pst;
        err_now = 1'b0;
        el_len = 5'h00;
        after_seq_go = 1'b0;
        case (pst)
            P_SEQ_HDR:
                if (req_data_i[7:3] != DE_TYPE_SEQ)
                    err_now = 1'b1;
                else if (req_data_i[2:0] == DE_IDX_LEN8 || req_data_i[2:0] == DE_IDX_LEN16)
                    next_pst = P_SEQ_LEN;
                else
                    err_now = 1'b1;
            P_SEQ_LEN:
                if (!lcnt)
                begin
                    next_pst = P_EL_HDR;
                    if (new_len == 16'h0000)
                    begin
                        after_seq_go = 1'b1;
                        err_now = !phase;
                    end
                end
            P_EL_HDR:
            begin
                if (req_data_i[2:0] == DE_IDX_2B)
                    el_len = LEN_2B;
                else if (req_data_i[2:0] == DE_IDX_4B)
                    el_len = LEN_4B;
                else if (!phase && req_data_i[2:0] == DE_IDX_16B)
                    el_len = LEN_16B;
                if (req_data_i[7:3] != (phase ? DE_TYPE_UINT : DE_TYPE_UUID))
                    el_len = 5'h00;
                err_now = phase ? nids == RANGE_MAX_CNT : uuid_cnt == UUID_MAX;
                if (el_len == 5'h00 || seq_rem < {11'h000, el_len} + 16'h0001)
                    err_now = 1'b1;
                next_pst = P_EL_BODY;
            end
            P_EL_BODY:
                if (el_rem == 5'h01)
                begin
                    next_pst = P_EL_HDR;
                    after_seq_go = seq_rem == 16'h0000;
                    // ids must climb strictly and ranges must not invert
                    if (phase && (v_start > v_end || (nids != 4'h0 && v_start <= rng_hi[nids[2:0] - 3'h1])))
                        err_now = 1'b1;
                end
            P_LIMIT:
                if (!lcnt)
                begin
                    next_pst = P_SEQ_HDR;
                    err_now = new_len < LIMIT_MIN;
                end
            P_CONT_CNT:
            begin
                next_pst = (req_data_i == 8'h00) ? P_END : P_CONT_BYTE;
                err_now = req_data_i > CONT_MAX;
            end
            P_CONT_BYTE:
                if (el_rem == 5'h01)
                    next_pst = P_END;
            default:
                err_now = 1'b1;
        endcase
        if (after_seq_go)
            next_pst = phase ? P_CONT_CNT : P_LIMIT;
        if (err_now)
            next_pst = P_END;
    end

    // parser walk through the request fields
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            pst <= P_SEQ_HDR;
            phase <= 1'b0;
            seq_rem <= 16'h0000;
            el_rem <= 5'h00;
            lcnt <= 1'b0;
            uuid_cnt <= 4'h0;
            nids <= 4'h0;
            tok_len <= 8'h00;
            reply_byte_limit_o <= LIMIT_MIN;
        end
        else if (req_fire)
        begin
            pst <= req_last_i ? P_SEQ_HDR : next_pst;
            if (req_last_i)
                phase <= 1'b0;
            case (pst)
                P_SEQ_HDR:
                begin
                    seq_rem <= 16'h0000;
                    lcnt <= req_data_i[2:0] == DE_IDX_LEN16;
                    if (!phase)
                    begin
                        uuid_cnt <= 4'h0;
                        nids <= 4'h0;
                        tok_len <= 8'h00;
                    end
                end
                P_SEQ_LEN:
                begin
                    seq_rem <= new_len;
                    lcnt <= 1'b0;
                end
                P_EL_HDR:
                begin
                    seq_rem <= seq_rem - {11'h000, el_len} - 16'h0001;
                    el_rem <= el_len;
                    el32 <= el_len == LEN_4B;
                end
                P_EL_BODY:
                begin
                    el_rem <= el_rem - 5'h01;
                    shreg <= ival[23:0];
                    if (el_rem == 5'h01 && !phase)
                        uuid_cnt <= uuid_cnt + 4'h1;
                    if (el_rem == 5'h01 && phase && !err_now)
                    begin
                        rng_lo[nids[2:0]] <= v_start;
                        rng_hi[nids[2:0]] <= v_end;
                        nids <= nids + 4'h1;
                    end
                end
                P_LIMIT:
                begin
                    reply_byte_limit_o <= new_len;
                    seq_rem <= {8'h00, req_data_i};
                    lcnt <= 1'b0;
                    if (!lcnt)
                        phase <= 1'b1;
                end
                P_CONT_CNT:
                begin
                    tok_len <= req_data_i;
                    el_rem <= req_data_i[4:0];
                end
                P_CONT_BYTE:
                begin
                    el_rem <= el_rem - 5'h01;
                    tok <= {tok[7:0], req_data_i};
                end
            endcase
            if (after_seq_go)
                lcnt <= !phase;
        end
    end

    // done pulse and malformed flag, judged on the last byte
    logic bad_acc;
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            bad_acc <= 1'b0;
            req_done_o <= 1'b0;
            req_bad_o <= 1'b0;
        end
        else if (ce_i)
        begin
            req_done_o <= req_fire && req_last_i;
            if (req_fire)
            begin
                bad_acc <= req_last_i ? 1'b0 : (bad_acc | err_now);
                if (req_last_i)
                    req_bad_o <= bad_acc | err_now | (next_pst != P_END);
            end
        end
    end

    // range match against every stored entry
    logic [RANGE_MAX-1:0] hit;
    logic [RANGE_MAX-1:0] all_hit;
    for (genvar g = 0; g < RANGE_MAX; g++)
    begin : g_rng
        assign hit[g] = (4'(g) < nids) && rec_id_i >= rng_lo[g] && rec_id_i <= rng_hi[g];
        assign all_hit[g] = (4'(g) < nids) && rng_lo[g] == ID_FIRST && rng_hi[g] == ID_LAST;
    end
    assign select_all_o = |all_hit;

    // response framer
    logic [15:0] acc;
    logic [15:0] list_len;
    logic trunc;
    logic [15:0] next_id;
    logic seen;
    logic [15:0] last_id;
    logic [15:0] cur_id;
    logic [7:0] vrem;
    logic lastf;
    logic drop;
    logic [2:0] eidx;
    logic cand;
    logic fits;
    logic incl;
    logic attr_acc;
    logic push;
    logic [7:0] pbyte;
    logic plast;
    logic fifo_in_ready;
    logic fire;
    logic [16:0] need;

    assign need = {1'b0, acc} + {1'b0, SEQ_HDR_LEN} + {1'b0, ID_ELEM_LEN} + {9'h000, rec_vlen_i};
    assign fits = need <= {1'b0, reply_byte_limit_o};
    assign cand = (|hit) && !rec_null_i && !trunc
        && (tok_len != TOKEN_LEN || rec_id_i >= tok)
        && (!seen || rec_id_i > last_id);
    assign incl = cand && fits;
    assign rec_attr_ready_o = ce_i && (est == E_SIZE || est == E_ATTR);
    assign attr_acc = rec_attr_valid_i && rec_attr_ready_o;
    assign rec_pass_o = est != E_SIZE;
    assign rec_byte_ready_o = ce_i && est == E_VAL && (drop || fifo_in_ready);
    assign req_ready_o = est == E_IDLE && !req_done_o;
    assign busy_o = est != E_IDLE;
    assign fire = ce_i && push && fifo_in_ready;

    always_comb
    begin
        push = 1'b0;
        pbyte = 8'h00;
        plast = 1'b0;
        case (est)
            E_HDR:
            begin
                push = 1'b1;
                pbyte = (eidx == 3'h0) ? list_len[15:8] : (eidx == 3'h1) ? list_len[7:0] :
                    (eidx == 3'h2) ? SEQ16_HDR : (eidx == 3'h3) ? acc[15:8] : acc[7:0];
            end
            E_ID:
            begin
                push = 1'b1;
                pbyte = (eidx == 3'h0) ? ID_ELEM_HDR : ((eidx == 3'h1) ? cur_id[15:8] : cur_id[7:0]);
            end
            E_VAL:
            begin
                push = rec_byte_valid_i && !drop;
                pbyte = rec_byte_i;
            end
            E_CONT:
            begin
                push = 1'b1;
                if (!trunc || eidx == 3'h0)
                    pbyte = trunc ? TOKEN_LEN : 8'h00;
                else
                    pbyte = (eidx == 3'h1) ? next_id[15:8] : next_id[7:0];
                plast = !trunc || eidx == 3'h2;
            end
            default:
                push = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            est <= E_IDLE;
            acc <= 16'h0000;
            trunc <= 1'b0;
            seen <= 1'b0;
            eidx <= 3'h0;
        end
        else if (ce_i)
        begin
            // both passes see the same descriptors, so they take the same choices
            if (attr_acc)
            begin
                cur_id <= rec_id_i;
                vrem <= rec_vlen_i;
                lastf <= rec_attr_last_i;
                drop <= !incl;
                if (incl)
                begin
                    acc <= need[15:0] - SEQ_HDR_LEN;
                    seen <= 1'b1;
                    last_id <= rec_id_i;
                end
                if (cand && !fits)
                begin
                    trunc <= 1'b1;
                    next_id <= rec_id_i;
                end
            end
            // value bytes must not advance the token byte index
            eidx <= (fire && est != E_VAL) ? eidx + 3'h1 : eidx;
            case (est)
                E_IDLE:
                    if (req_done_o && !req_bad_o)
                    begin
                        est <= E_SIZE;
                        acc <= 16'h0000;
                        trunc <= 1'b0;
                        seen <= 1'b0;
                    end
                E_SIZE:
                    if (attr_acc && rec_attr_last_i)
                    begin
                        est <= E_HDR;
                        list_len <= (incl ? need[15:0] : acc + SEQ_HDR_LEN);
                        acc <= (incl ? need[15:0] : acc + SEQ_HDR_LEN) - SEQ_HDR_LEN;
                        trunc <= trunc || (cand && !fits);
                        seen <= 1'b0;
                        eidx <= 3'h0;
                    end
                E_HDR:
                    if (fire && eidx == 3'h4)
                    begin
                        est <= E_ATTR;
                        acc <= 16'h0000;
                        trunc <= 1'b0;
                    end
                E_ATTR:
                    if (attr_acc)
                    begin
                        eidx <= 3'h0;
                        if (incl)
                            est <= E_ID;
                        else if (rec_vlen_i != 8'h00)
                            est <= E_VAL;
                        else if (rec_attr_last_i)
                            est <= E_CONT;
                    end
                E_ID:
                    if (fire && eidx == 3'h2)
                    begin
                        eidx <= 3'h0;
                        est <= (vrem != 8'h00) ? E_VAL : (lastf ? E_CONT : E_ATTR);
                    end
                E_VAL:
                    if (rec_byte_valid_i && rec_byte_ready_o)
                    begin
                        vrem <= vrem - 8'h01;
                        if (vrem == 8'h01)
                            est <= lastf ? E_CONT : E_ATTR;
                    end
                default:
                    if (fire && plast)
                        est <= E_IDLE;
            endcase
        end
    end

    // the buffer lets the framer run ahead of a slow response sink
    logic [FIFO_WIDTH-1:0] fifo_out;
    sapc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(push),
        .in_data_i({plast, pbyte}),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(resp_valid_o),
        .out_data_o(fifo_out),
        .out_ready_i(resp_ready_i)
    );
    assign resp_data_o = fifo_out[7:0];
    assign resp_last_o = fifo_out[8];
endmodule

// [bench/sapc_codec_assertions.sv]
// checker of the codec request and response handshakes
module sapc_codec_assertions (
    // watched ports
    input logic clk_sys_i,
    input logic rst_b_i,
    input logic ce_i,
    input logic req_valid_i,
    input logic req_last_i,
    input logic req_ready_o,
    input logic req_done_o,
    input logic req_bad_o,
    input logic [15:0] reply_byte_limit_o,
    input logic select_all_o,
    input logic rec_attr_ready_o,
    input logic resp_valid_o,
    input logic [7:0] resp_data_o,
    input logic resp_last_o,
    input logic resp_ready_i,
    input logic busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    logic take;
    assign take = ce_i && req_valid_i && req_ready_o;
    a_done_one_cycle: assert property (req_done_o |=> !req_done_o)
        else $error("long done");
    a_done_after_last: assert property (take && req_last_i |=> req_done_o)
        else $error("no done");
    a_done_has_cause: assert property (req_done_o |-> $past(take && req_last_i))
        else $error("stray done");
    a_ready_refused: assert property (busy_o || req_done_o |-> !req_ready_o)
        else $error("ready while busy");
    a_resp_held: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable({resp_data_o, resp_last_o}))
        else $error("byte lost");
    a_limit_stable: assert property (!take |=> $stable(reply_byte_limit_o))
        else $error("limit moved");
    a_select_stable: assert property (!take |=> $stable(select_all_o))
        else $error("select moved");
    a_good_starts: assert property (req_done_o && !req_bad_o |=> busy_o)
        else $error("no answer");
    a_bad_quiet: assert property (req_done_o && req_bad_o |=> !busy_o [*3])
        else $error("bad request answered");
    a_rec_busy: assert property (rec_attr_ready_o |-> busy_o)
        else $error("idle take");
endmodule
bind sapc_codec sapc_codec_assertions chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .req_valid_i(req_valid_i), .req_last_i(req_last_i), .req_ready_o(req_ready_o), .req_done_o(req_done_o),
    .req_bad_o(req_bad_o), .reply_byte_limit_o(reply_byte_limit_o), .select_all_o(select_all_o),
    .rec_attr_ready_o(rec_attr_ready_o), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .resp_last_o(resp_last_o), .resp_ready_i(resp_ready_i), .busy_o(busy_o));

// [bench/sapc_client_model.sv]
// client model: sends a request image and drains the reply with stalls
module sapc_client_model (
    // clock and reset
    input logic clk_sys_i,
    input logic rst_b_i,
    // request image
    input logic go_i,
    input logic [6:0] len_i,
    input logic [7:0] mem_i [0:63],
    // codec request side
    output logic req_valid_o,
    output logic [7:0] req_data_o,
    output logic req_last_o,
    input logic req_ready_i,
    // codec response side
    output logic resp_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 74929;
    initial resp_ready_o = 1'b0;
    // random stalls let the reply fifo fill up
    always @(posedge clk_sys_i)
        resp_ready_o <= #10 rst_b_i && ($random(seed) % 3 != 0);
    initial
    begin : send
        int k;
        {req_valid_o, req_data_o, req_last_o} = '0;
        forever
        begin
            @(posedge clk_sys_i);
            if (go_i === 1'b1)
            begin
                #10;
                for (k = 0; k < len_i; k++)
                begin
                    req_valid_o = 1'b1;
                    req_data_o = mem_i[k];
                    req_last_o = (k == len_i - 1);
                    do @(posedge clk_sys_i); while (req_ready_i !== 1'b1);
                    #10;
                end
                req_valid_o = 1'b0;
                // a released bus does not keep its last value
                req_data_o = ~req_data_o;
                req_last_o = 1'b0;
            end
        end
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench of the attribute pdu codec
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic go = 1'b0;
    logic got_end;
    logic req_valid, req_last, req_ready, req_done, req_bad, sel_all, resp_valid, resp_last, resp_ready, busy;
    logic rec_av, rec_null, rec_last, rec_ar, rec_pass, rec_bv, rec_br;
    logic [7:0] req_data, resp_data, rec_byte, rec_vlen;
    logic [15:0] lim_o, rec_id;
    logic [7:0] mem [0:63];
    logic [6:0] len;
    logic [7:0] got_q[$], exp_q[$];
    logic [15:0] ids [0:3] = '{16'h0000, 16'h0001, 16'h0004, 16'h0100};
    logic [7:0] vl [0:3] = '{8'h05, 8'h00, 8'h03, 8'h03};
    logic [7:0] val [0:3][0:4];
    logic [7:0] idl [0:2][0:7] = '{'{8'h35, 8'h05, 8'h0a, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00},
        '{8'h35, 8'h06, 8'h09, 8'h00, 8'h04, 8'h09, 8'h01, 8'h00},
        '{8'h35, 8'h06, 8'h09, 8'h01, 8'h00, 8'h09, 8'h00, 8'h04}};
    integer seed = 74929;
    int fail_count = 0;
    int samples_checked = 0;
    initial forever #50 clk_sys_i = ~clk_sys_i;
    sapc_codec dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .req_valid_i(req_valid),
        .req_data_i(req_data), .req_last_i(req_last), .req_ready_o(req_ready), .req_done_o(req_done),
        .req_bad_o(req_bad), .reply_byte_limit_o(lim_o), .select_all_o(sel_all), .rec_attr_valid_i(rec_av),
        .rec_id_i(rec_id), .rec_null_i(rec_null), .rec_vlen_i(rec_vlen), .rec_attr_last_i(rec_last),
        .rec_attr_ready_o(rec_ar), .rec_pass_o(rec_pass), .rec_byte_valid_i(rec_bv), .rec_byte_i(rec_byte),
        .rec_byte_ready_o(rec_br), .resp_valid_o(resp_valid), .resp_data_o(resp_data), .resp_last_o(resp_last),
        .resp_ready_i(resp_ready), .busy_o(busy));
    sapc_client_model cli_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .go_i(go), .len_i(len), .mem_i(mem),
        .req_valid_o(req_valid), .req_data_o(req_data), .req_last_o(req_last), .req_ready_i(req_ready),
        .resp_ready_o(resp_ready));
    always @(posedge clk_sys_i)
        if (resp_valid === 1'b1 && resp_ready === 1'b1)
        begin
            got_q.push_back(resp_data);
            got_end <= resp_last;
        end
    // record source: value bytes only in emit pass
    initial
    begin : rec_src
        int i;
        int b;
        logic p;
        {rec_av, rec_bv, rec_null, rec_last, rec_id, rec_vlen, rec_byte} = '0;
        forever
            for (i = 0; i < 4; i++)
            begin
                {rec_av, rec_id, rec_null, rec_vlen, rec_last} = {1'b1, ids[i], vl[i] == 0, vl[i], i == 3};
                do @(posedge clk_sys_i); while (rec_ar !== 1'b1);
                p = rec_pass;
                #10;
                for (b = 0; b < vl[i] && p; b++)
                begin
                    {rec_bv, rec_byte} = {1'b1, val[i][b]};
                    do @(posedge clk_sys_i); while (rec_br !== 1'b1);
                    #10 rec_bv = 1'b0;
                end
            end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic time_out(input int k);
        if (k >= 2000)
        begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic put(input logic [7:0] b);
        mem[len] = b;
        len++;
    endtask
    task automatic make_req(input int n, input logic [15:0] lim, input int mode, input int tc, input logic [15:0] tok);
        int k;
        len = 0;
        put(8'h35);
        put(8'(3 * n));
        for (k = 0; k < 3 * n; k++)
            put(k % 3 == 0 ? 8'h19 : 8'($random(seed)));
        put(lim[15:8]);
        put(lim[7:0]);
        for (k = 0; k < 7 + (mode > 0); k++)
            put(idl[mode][k]);
        put(8'(tc));
        for (k = 0; k < tc; k++)
            put(tc == 2 ? (k == 0 ? tok[15:8] : tok[7:0]) : 8'h00);
    endtask
    function automatic void build_exp(input logic [15:0] lim, input logic [3:0] sel, input logic [15:0] from);
        int i;
        int b;
        int acc;
        logic cut;
        logic [7:0] body[$];
        {acc, cut} = {32'd3, 1'b0};
        exp_q = '{8'h00};
        for (i = 0; i < 4; i++)
            if (sel[i] && vl[i] != 0 && ids[i] >= from && !cut)
            begin
                if (acc + 3 + vl[i] > lim)
                begin
                    cut = 1'b1;
                    exp_q = '{8'h02, ids[i][15:8], ids[i][7:0]};
                end
                else
                begin
                    acc += 3 + vl[i];
                    body = {body, 8'h09, ids[i][15:8], ids[i][7:0]};
                    for (b = 0; b < vl[i]; b++)
                        body.push_back(val[i][b]);
                end
            end
        exp_q = {8'(acc >> 8), 8'(acc), 8'h36, 8'((acc - 3) >> 8), 8'(acc - 3), body, exp_q};
    endfunction
    task automatic run(input logic bad, input logic [15:0] lim, input logic [3:0] sel, input logic [15:0] from);
        int k;
        got_q.delete();
        got_end = 1'b0;
        @(posedge clk_sys_i);
        #10 go = 1'b1;
        @(posedge clk_sys_i);
        #10 go = 1'b0;
        for (k = 0; k < 2000 && req_done !== 1'b1; k++)
            @(posedge clk_sys_i) #10;
        time_out(k);
        check(req_bad, bad);
        if (bad)
            repeat (20) @(posedge clk_sys_i);
        build_exp(lim, sel, from);
        for (k = 0; k < 2000 && got_end !== 1'b1 && !bad; k++)
            @(posedge clk_sys_i) #10;
        time_out(k);
        check(got_q.size(), bad ? 0 : exp_q.size());
        for (k = 0; k < exp_q.size() && !bad; k++)
            check(got_q[k], exp_q[k]);
        $display("test done lim=%h bad=%0d", lim, bad);
    endtask
    initial
    begin : main
        int r;
        logic [15:0] lim;
        for (r = 0; r < 20; r++)
            val[r / 5][r % 5] = (r % 5 != 0) ? 8'($random(seed)) : (r < 5 ? 8'h0a : 8'h09);
        repeat (20) @(posedge clk_sys_i);
        #10 rst_b_i = 1'b1;
        check(lim_o, 16'h0009);
        make_req(1, 16'hffff, 0, 0, 16'h0000);
        run(1'b0, 16'hffff, 4'hf, 16'h0000);
        check(sel_all, 1'b1);
        make_req(12, 16'h0009, 1, 0, 16'h0000);
        run(1'b0, 16'h0009, 4'hc, 16'h0000);
        check(sel_all, 1'b0);
        make_req(12, 16'h0009, 1, 2, 16'h0100);
        run(1'b0, 16'h0009, 4'hc, 16'h0100);
        for (r = 0; r < 5; r++)
        begin
            lim = (r == 2) ? 16'h0008 : 16'hffff;
            make_req((r == 0) ? 0 : (r == 1) ? 13 : 1, lim, (r == 3) ? 2 : 0, (r == 4) ? 17 : 0, 16'h0000);
            run(1'b1, lim, 4'h0, 16'h0000);
        end
        for (r = 0; r < 4; r++)
        begin
            lim = 16'h0009 + ($random(seed) & 16'h001f);
            make_req(1, lim, 0, 0, 16'h0000);
            run(1'b0, lim, 4'hf, 16'h0000);
        end
        close_out();
    end
endmodule
